// ### logic/dma_ack_pkg.sv
// Shared constants and types for the DMA request, acknowledge and end block
package dma_ack_pkg;
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned CHAN_BITS = 2;
  localparam int unsigned FIFO_WORDS = 8;
  localparam int unsigned ADDR_BITS = 32;
  localparam int unsigned DATA_BITS = 32;
  localparam int unsigned COUNT_BITS = 16;
  localparam logic [2:0] REQ_MASK_EXTERNAL_BUS_CLOCK = 3'h4;
  localparam logic [2:0] MASK_IDLE = 3'h0;
  localparam logic [3:0] STEP_BYTES = 4'h4;
  localparam logic ADDR_LSB_FORCED = 1'h0;
  typedef enum logic [1:0] {AREA_EXT, AREA_IRAM, AREA_PERIPH} area_t;
  typedef enum {ST_IDLE, ST_LOAD, ST_MOVE} xfer_state_t;
endpackage

// ### logic/dma_fifo.sv
// Word FIFO that buffers read data between the source and destination cycles
`timescale 1ns/10ps
module dma_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fill and drain sides
  dma_stream_if.sink in_s,
  dma_stream_if.source out_s
);
  localparam int unsigned PW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("dma_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW:0] wr_ptr_r;
  logic [PW:0] rd_ptr_r;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = wr_ptr_r == rd_ptr_r;
  assign full = (wr_ptr_r[PW] != rd_ptr_r[PW]) && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem_r[rd_ptr_r[PW-1:0]];
  assign push = in_s.valid && !full;
  assign pop = out_s.ready && !empty;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r[PW-1:0]] <= in_s.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'h1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'h1;
      end
    end
  end
endmodule

// ### logic/dma_request_ack_and_end.sv
// Four-channel DMA request, acknowledge, suspension and transfer-end logic
`timescale 1ns/10ps
module dma_request_ack_and_end #(
  parameter int unsigned ADDR_W = 32,
  parameter int unsigned DATA_W = 32,
  parameter int unsigned CNT_W = 16,
  parameter int unsigned FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // External request pins
  input wire logic [dma_ack_pkg::NUM_CHAN-1:0] chan_request_in_n,
  input wire logic external_bus_clock,
  output logic [dma_ack_pkg::NUM_CHAN-1:0] chan_ack_out_n,
  output logic [dma_ack_pkg::NUM_CHAN-1:0] terminal_count_n,
  // Channel control and status
  input wire logic [dma_ack_pkg::NUM_CHAN-1:0] chan_enable,
  input wire logic [dma_ack_pkg::NUM_CHAN-1:0] sw_start,
  input wire logic [dma_ack_pkg::NUM_CHAN-1:0] tc_clear,
  output logic [dma_ack_pkg::NUM_CHAN-1:0] tc_status,
  output logic [dma_ack_pkg::NUM_CHAN-1:0] transfer_end_irq,
  // Channel setup
  input wire logic setup_valid,
  input wire logic [dma_ack_pkg::CHAN_BITS-1:0] setup_chan,
  input wire logic [ADDR_W-1:0] setup_src,
  input wire logic [ADDR_W-1:0] setup_dst,
  input wire dma_ack_pkg::area_t setup_src_area,
  input wire dma_ack_pkg::area_t setup_dst_area,
  input wire logic [CNT_W-1:0] setup_count,
  // Suspension sources
  input wire logic bus_hold_grant,
  input wire logic refresh_active,
  // Memory bus
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output dma_ack_pkg::area_t mem_area,
  output logic [DATA_W-1:0] mem_wdata,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic mem_ack,
  // CPU arbitration
  output logic cpu_rom_grant,
  output logic cpu_ram_grant,
  output logic dma_busy
);
  import dma_ack_pkg::*;

  if (ADDR_W < 4 || DATA_W < 1 || CNT_W < 2 || FIFO_DEPTH < 2) begin : g_bad_param
    $error("dma_request_ack_and_end parameters out of range");
  end

  function automatic logic [ADDR_W-1:0] align_addr(input logic [ADDR_W-1:0] a);
    align_addr = {a[ADDR_W-1:1], ADDR_LSB_FORCED};
  endfunction

  function automatic logic [NUM_CHAN-1:0] chan_bit(input logic [CHAN_BITS-1:0] c);
    chan_bit = {{(NUM_CHAN-1){1'h0}}, 1'h1} << c;
  endfunction

  function automatic logic [CHAN_BITS-1:0] pick_chan(input logic [NUM_CHAN-1:0] p);
    pick_chan = '0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (p[i]) begin
        pick_chan = CHAN_BITS'(i);
      end
    end
  endfunction

  logic [ADDR_W-1:0] cfg_src_r [NUM_CHAN];
  logic [ADDR_W-1:0] cfg_dst_r [NUM_CHAN];
  area_t cfg_src_area_r [NUM_CHAN];
  area_t cfg_dst_area_r [NUM_CHAN];
  logic [CNT_W-1:0] cfg_cnt_r [NUM_CHAN];

  xfer_state_t state_r;
  logic [CHAN_BITS-1:0] cur_chan_r;
  logic [CHAN_BITS-1:0] tc_chan_r;
  logic [ADDR_W-1:0] src_r;
  logic [ADDR_W-1:0] dst_r;
  area_t area_src_r;
  area_t area_dst_r;
  logic [CNT_W-1:0] rd_left_r;
  logic [CNT_W-1:0] wr_left_r;
  logic mem_req_r;
  logic mem_we_r;
  logic [ADDR_W-1:0] mem_addr_r;
  area_t mem_area_r;
  logic [DATA_W-1:0] mem_wdata_r;
  logic [NUM_CHAN-1:0] pend_r;
  logic external_bus_clock_q_r;
  logic [2:0] mask_cnt_r;
  logic tc_pend_r;
  logic [NUM_CHAN-1:0] tc_n_r;
  logic [NUM_CHAN-1:0] tc_status_r;
  logic [NUM_CHAN-1:0] irq_r;
  logic cpu_rom_grant_r;
  logic cpu_ram_grant_r;

  logic suspend;
  logic bus_rise;
  logic want_rd;
  logic want_wr;
  logic issue;
  logic issue_wr;
  logic last_wr;
  logic grant;
  logic finish;
  logic [NUM_CHAN-1:0] grant_bit;
  logic [NUM_CHAN-1:0] pin_req;
  logic [NUM_CHAN-1:0] busy_mask;

  dma_stream_if #(.W(DATA_W)) rd_s();
  dma_stream_if #(.W(DATA_W)) wr_s();

  dma_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_s(rd_s),
    .out_s(wr_s)
  );

  assign suspend = bus_hold_grant | refresh_active;
  assign bus_rise = external_bus_clock & ~external_bus_clock_q_r;
  assign want_rd = (state_r == ST_MOVE) && (rd_left_r != '0) && rd_s.ready;
  assign want_wr = (state_r == ST_MOVE) && (wr_left_r != '0) && wr_s.valid && ((rd_left_r == '0) || !rd_s.ready);
  // New bus cycles start only outside hold and refresh, and pick up again on their own
  assign issue = !mem_req_r && !suspend && (want_rd || want_wr);
  assign issue_wr = issue && want_wr;
  assign last_wr = issue_wr && (wr_left_r == CNT_W'(1));
  assign grant = (state_r == ST_IDLE) && (pend_r != '0);
  assign grant_bit = grant ? chan_bit(pick_chan(pend_r)) : '0;
  assign finish = (state_r == ST_MOVE) && (rd_left_r == '0) && (wr_left_r == '0) && !mem_req_r;
  assign pin_req = (bus_rise && mask_cnt_r == MASK_IDLE) ? ~chan_request_in_n : '0;
  // The served channel's pin is still held low until acknowledge, so it must not re-arm
  assign busy_mask = (state_r != ST_IDLE) ? chan_bit(cur_chan_r) : '0;

  assign rd_s.valid = mem_req_r && !mem_we_r && mem_ack;
  assign rd_s.data = mem_rdata;
  assign wr_s.ready = issue_wr;

  // Acknowledge on every non-RAM cycle, peripheral cycles included
  assign chan_ack_out_n = (mem_req_r && mem_area_r != AREA_IRAM) ? ~chan_bit(cur_chan_r) : '1;
  assign terminal_count_n = tc_n_r;
  assign tc_status = tc_status_r;
  assign transfer_end_irq = irq_r;
  assign mem_req = mem_req_r;
  assign mem_we = mem_we_r;
  assign mem_addr = mem_addr_r;
  assign mem_area = mem_area_r;
  assign mem_wdata = mem_wdata_r;
  assign cpu_rom_grant = cpu_rom_grant_r;
  assign cpu_ram_grant = cpu_ram_grant_r;
  assign dma_busy = state_r != ST_IDLE;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        cfg_src_r[i] <= '0;
        cfg_dst_r[i] <= '0;
        cfg_src_area_r[i] <= AREA_EXT;
        cfg_dst_area_r[i] <= AREA_EXT;
        cfg_cnt_r[i] <= '0;
      end
    end else if (setup_valid) begin
      cfg_src_r[setup_chan] <= setup_src;
      cfg_dst_r[setup_chan] <= setup_dst;
      cfg_src_area_r[setup_chan] <= setup_src_area;
      cfg_dst_area_r[setup_chan] <= setup_dst_area;
      cfg_cnt_r[setup_chan] <= setup_count;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      cur_chan_r <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (grant) begin
            cur_chan_r <= pick_chan(pend_r);
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: state_r <= ST_MOVE;
        ST_MOVE: begin
          if (finish) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      src_r <= '0;
      dst_r <= '0;
      area_src_r <= AREA_EXT;
      area_dst_r <= AREA_EXT;
      rd_left_r <= '0;
      wr_left_r <= '0;
      mem_req_r <= 1'h0;
      mem_we_r <= 1'h0;
      mem_addr_r <= '0;
      mem_area_r <= AREA_EXT;
      mem_wdata_r <= '0;
    end else if (state_r == ST_LOAD) begin
      src_r <= align_addr(cfg_src_r[cur_chan_r]);
      dst_r <= align_addr(cfg_dst_r[cur_chan_r]);
      area_src_r <= cfg_src_area_r[cur_chan_r];
      area_dst_r <= cfg_dst_area_r[cur_chan_r];
      rd_left_r <= cfg_cnt_r[cur_chan_r];
      wr_left_r <= cfg_cnt_r[cur_chan_r];
    end else if (issue) begin
      mem_req_r <= 1'h1;
      mem_we_r <= want_wr;
      if (want_wr) begin
        mem_addr_r <= dst_r;
        mem_area_r <= area_dst_r;
        mem_wdata_r <= wr_s.data;
        dst_r <= dst_r + ADDR_W'(STEP_BYTES);
        wr_left_r <= wr_left_r - 1'h1;
      end else begin
        mem_addr_r <= src_r;
        mem_area_r <= area_src_r;
        src_r <= src_r + ADDR_W'(STEP_BYTES);
        rd_left_r <= rd_left_r - 1'h1;
      end
    end else if (mem_req_r && mem_ack) begin
      mem_req_r <= 1'h0;
    end
  end

  // Bus clock copy runs through reset, so no false rise follows its release
  always_ff @(posedge clk) begin
    external_bus_clock_q_r <= external_bus_clock;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~grant_bit) | ((pin_req | sw_start) & chan_enable & ~tc_status_r & ~busy_mask & ~grant_bit);
    end
  end

  // Request pins stay masked for a few bus clocks after a transfer ends
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask_cnt_r <= MASK_IDLE;
    end else if (finish) begin
      mask_cnt_r <= REQ_MASK_EXTERNAL_BUS_CLOCK;
    end else if (bus_rise && mask_cnt_r != MASK_IDLE) begin
      mask_cnt_r <= mask_cnt_r - 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tc_pend_r <= 1'h0;
      tc_chan_r <= '0;
      tc_n_r <= '1;
    end else begin
      if (last_wr) begin
        tc_pend_r <= 1'h1;
        tc_chan_r <= cur_chan_r;
      end else if (bus_rise) begin
        tc_pend_r <= 1'h0;
      end
      if (bus_rise) begin
        tc_n_r <= tc_pend_r ? ~chan_bit(tc_chan_r) : '1;
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tc_status_r <= '0;
      irq_r <= '0;
    end else begin
      tc_status_r <= (tc_status_r & ~tc_clear) | (finish ? chan_bit(cur_chan_r) : '0);
      irq_r <= finish ? chan_bit(cur_chan_r) : '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cpu_rom_grant_r <= 1'h0;
      cpu_ram_grant_r <= 1'h0;
    end else begin
      cpu_rom_grant_r <= 1'h1;
      cpu_ram_grant_r <= (state_r == ST_IDLE) || (area_src_r != AREA_IRAM && area_dst_r != AREA_IRAM);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence seq_bus_free;
    !mem_req_r && !suspend && (want_rd || want_wr);
  endsequence
  sequence seq_tc_active;
    bus_rise && (terminal_count_n != '1);
  endsequence

  AST_ALIGN: assert property (mem_req_r |-> !mem_addr_r[0])
    else $error("odd address on the memory bus");
  AST_RAM_NO_ACK: assert property (mem_req_r && mem_area_r == AREA_IRAM |-> chan_ack_out_n == '1)
    else $error("acknowledge during internal RAM cycle");
  AST_EXT_ACK: assert property (mem_req_r && mem_area_r != AREA_IRAM |-> !chan_ack_out_n[cur_chan_r])
    else $error("missing acknowledge on external or peripheral cycle");
  AST_SUSPEND: assert property (suspend && !mem_req_r |=> !mem_req_r)
    else $error("bus cycle started while suspended");
  AST_RESUME: assert property (seq_bus_free |=> mem_req_r)
    else $error("transfer did not resume");
  AST_TC_STATUS: assert property (finish |=> tc_status_r[$past(cur_chan_r)] && irq_r == chan_bit($past(cur_chan_r)) ##1 irq_r == '0)
    else $error("transfer end not flagged");
  AST_MASK: assert property (finish |=> mask_cnt_r == REQ_MASK_EXTERNAL_BUS_CLOCK)
    else $error("request mask not loaded at transfer end");
  AST_GRANT_FLOW: assert property (grant |=> state_r == ST_LOAD ##1 state_r == ST_MOVE)
    else $error("granted request not started");
  AST_RAM_CPU: assert property (state_r == ST_MOVE && area_src_r == AREA_IRAM |=> !cpu_ram_grant && cpu_rom_grant)
    else $error("CPU arbitration wrong during transfer");
  AST_SAMPLE: assert property ((pend_r & ~$past(pend_r) & ~$past(sw_start)) != '0 |-> $past(bus_rise))
    else $error("request pin taken outside bus clock rise");
  AST_PRIORITY: assert property (grant |=>
    ($past(pend_r) & ((chan_bit(cur_chan_r) << 1) - 1'h1)) == chan_bit(cur_chan_r))
    else $error("granted channel is not the lowest pending one");
  AST_TC_ONE_CLK: assert property (seq_tc_active |=> terminal_count_n == '1 || $past(tc_pend_r))
    else $error("terminal count longer than one bus clock");
  AST_TC_EDGE: assert property ($changed(terminal_count_n) |-> $past(bus_rise))
    else $error("terminal count changed off the bus clock rise");
endmodule

// ### logic/dma_stream_if.sv
// Valid/ready word stream between the transfer engine and its buffer
`timescale 1ns/10ps
interface dma_stream_if #(parameter int unsigned W = 32);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface

// ### verification/dma_mem_model.sv
// Memory target that answers DMA bus cycles after a set latency
`timescale 1ns/10ps
module dma_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus cycle from the block
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [3:0] lat,
  // Answer
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [3:0] wait_r;
  logic [31:0] pat_r;
  always @(posedge clk) begin
    if (!rstn) begin
      mem_ack <= 1'b0;
      wait_r <= 4'h0;
      pat_r <= 32'h1234_0001;
      mem_rdata <= 32'h0000_0000;
    end else if (mem_ack || !mem_req) begin
      // Released data lines show a changing pattern
      mem_ack <= 1'b0;
      wait_r <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_r >= lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_we ? ~mem_rdata : pat_r;
      pat_r <= pat_r + 32'h0101_0101;
    end else begin
      wait_r <= wait_r + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ### verification/dma_request_ack_and_end_tb.sv
// Self-checking bench for the DMA request, acknowledge and end block
`timescale 1ns/10ps
`define CHECK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module dma_request_ack_and_end_tb;
  import dma_ack_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, external_bus_clock = 1'b0, setup_valid = 1'b0;
  logic bus_hold_grant = 1'b0, refresh_active = 1'b0, prev_req = 1'b0, prev_susp = 1'b0, prev_rstn = 1'b0;
  logic [3:0] chan_request_in_n = 4'hF, chan_enable = 4'hF, sw_start = 4'h0, tc_clear = 4'h0;
  logic [3:0] lat = 4'h0, active = 4'h0, chan_ack_out_n, terminal_count_n, tc_status, transfer_end_irq;
  logic [1:0] setup_chan = 2'h0, bus_cnt = 2'h0;
  logic [31:0] setup_src = 32'h0000_0000, setup_dst = 32'h0000_0000, mem_addr, mem_wdata, mem_rdata;
  logic [15:0] setup_count = 16'h0000;
  area_t setup_src_area = AREA_EXT, setup_dst_area = AREA_EXT, mem_area;
  logic mem_req, mem_we, mem_ack, cpu_rom_grant, cpu_ram_grant, dma_busy;
  logic [31:0] src_a [4], dst_a [4], rd_q [$];
  area_t sa_a [4], da_a [4];
  int cnt_a [4], rd_n [4], wr_n [4], irq_n [4], tcp_n [4], tc_low [4];
  int mismatches = 0, cmp_count = 0, idle = 0;

  dma_request_ack_and_end i_dut (.clk(clk), .rstn(rstn), .chan_request_in_n(chan_request_in_n),
    .external_bus_clock(external_bus_clock), .chan_ack_out_n(chan_ack_out_n),
    .terminal_count_n(terminal_count_n), .chan_enable(chan_enable), .sw_start(sw_start),
    .tc_clear(tc_clear), .tc_status(tc_status), .transfer_end_irq(transfer_end_irq),
    .setup_valid(setup_valid), .setup_chan(setup_chan), .setup_src(setup_src), .setup_dst(setup_dst),
    .setup_src_area(setup_src_area), .setup_dst_area(setup_dst_area), .setup_count(setup_count),
    .bus_hold_grant(bus_hold_grant), .refresh_active(refresh_active), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_area(mem_area), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .cpu_rom_grant(cpu_rom_grant),
    .cpu_ram_grant(cpu_ram_grant), .dma_busy(dma_busy));
  dma_mem_model i_mem (.clk(clk), .rstn(rstn), .mem_req(mem_req), .mem_we(mem_we), .lat(lat),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  always #50 clk = ~clk;
  // Bus clock at a quarter of the system clock
  always @(posedge clk) begin
    bus_cnt <= bus_cnt + 2'h1;
    external_bus_clock <= bus_cnt[1];
  end

  function automatic int cur_ch();
    for (int c = 0; c < 4; c++) if (active[c] && tc_status[c] !== 1'b1) return c;
    return 0;
  endfunction

  // Bus monitor, sampling settled values between rising edges
  always @(negedge clk) begin
    int c;
    logic [3:0] ea;
    logic [31:0] w;
    c = cur_ch();
    ea = 4'hF;
    if (rstn && prev_rstn) begin
      if (mem_req && mem_area != AREA_IRAM) ea[c] = 1'b0;
      `CHECK("ack_n", ea, chan_ack_out_n)
      `CHECK("rom_grant", 1'b1, cpu_rom_grant)
      if (mem_req) begin
        `CHECK("addr_lsb", 1'b0, mem_addr[0])
        `CHECK("ram_grant", !(sa_a[c] == AREA_IRAM || da_a[c] == AREA_IRAM), cpu_ram_grant)
        if (!prev_req) `CHECK("issue_suspended", 1'b0, prev_susp)
        if (mem_ack && !mem_we) begin
          `CHECK("rd_addr", (src_a[c] & 32'hFFFF_FFFE) + (32'(rd_n[c]) << 2), mem_addr)
          rd_q.push_back(mem_rdata);
          rd_n[c]++;
        end
        if (mem_ack && mem_we) begin
          w = (rd_q.size() > 0) ? rd_q.pop_front() : 32'h0000_0000;
          `CHECK("wr_addr", (dst_a[c] & 32'hFFFF_FFFE) + (32'(wr_n[c]) << 2), mem_addr)
          `CHECK("wr_data", w, mem_wdata)
          wr_n[c]++;
        end
      end
      idle = (dma_busy && !mem_req && !bus_hold_grant && !refresh_active) ? idle + 1 : 0;
      `CHECK("resume_gap", 1'b1, idle < 9)
      for (int k = 0; k < 4; k++) begin
        if (transfer_end_irq[k] === 1'b1) irq_n[k]++;
        if (terminal_count_n[k] === 1'b0) begin
          tc_low[k]++;
        end else if (tc_low[k] != 0) begin
          `CHECK("tc_len", 4, tc_low[k])
          tcp_n[k]++;
          tc_low[k] = 0;
        end
      end
    end
    prev_req = mem_req;
    prev_susp = bus_hold_grant | refresh_active;
    prev_rstn = rstn;
  end

  task automatic give_verdict();
    begin
      $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask

  task automatic setup(input int ch, input logic [31:0] s, d, input area_t sa, da, input int n);
    begin
      @(posedge clk);
      setup_valid <= 1'b1;
      setup_chan <= 2'(ch);
      setup_src <= s;
      setup_dst <= d;
      setup_src_area <= sa;
      setup_dst_area <= da;
      setup_count <= 16'(n);
      src_a[ch] = s;
      dst_a[ch] = d;
      sa_a[ch] = sa;
      da_a[ch] = da;
      cnt_a[ch] = n;
      @(posedge clk);
      setup_valid <= 1'b0;
    end
  endtask

  // Starts the channels in m by pin or software, waits for their ends and judges them
  task automatic run(input logic [3:0] m, input bit pin, input bit susp, input logic [3:0] l);
    int k;
    logic done;
    logic [3:0] rel;
    begin
      active = m;
      rd_q.delete();
      rd_n = '{0, 0, 0, 0};
      wr_n = '{0, 0, 0, 0};
      irq_n = '{0, 0, 0, 0};
      tcp_n = '{0, 0, 0, 0};
      @(posedge clk);
      lat <= l;
      if (pin) chan_request_in_n <= ~m; else sw_start <= m;
      done = 1'b0;
      for (k = 0; k < 3000 && !done; k++) begin
        @(negedge clk);
        done = (tc_status & m) === m;
        rel = ~chan_ack_out_n | tc_status;
        @(posedge clk);
        sw_start <= 4'h0;
        chan_request_in_n <= chan_request_in_n | rel;
        if (susp) begin
          bus_hold_grant <= (k >= 30 && k < 50);
          refresh_active <= (k >= 50 && k < 70);
        end
      end
      if (!done) begin
        `CHECK("transfer_end", m, tc_status & m)
        give_verdict();
      end
      repeat (12) @(posedge clk);
      for (int c = 0; c < 4; c++) begin
        if (m[c]) begin
          `CHECK("rd_count", cnt_a[c], rd_n[c])
          `CHECK("wr_count", cnt_a[c], wr_n[c])
          `CHECK("irq_count", 1, irq_n[c])
          `CHECK("tc_pulses", 1, tcp_n[c])
          `CHECK("tc_status", 1'b1, tc_status[c])
        end
      end
      tc_clear <= m;
      bus_hold_grant <= 1'b0;
      refresh_active <= 1'b0;
      @(posedge clk);
      tc_clear <= 4'h0;
      repeat (20) @(posedge clk);
      `CHECK("tc_cleared", 4'h0, tc_status & m)
    end
  endtask

  // Odd addresses, nine words through the eight-word buffer, slow target
  task automatic sc_fifo_ext();
    begin
      setup(0, 32'h0000_1001, 32'h0000_2003, AREA_EXT, AREA_EXT, 9);
      run(4'h1, 1'b1, 1'b0, 4'h3);
      $display("Test fifo_ext done");
    end
  endtask

  // No code runs from internal RAM during these transfers
  task automatic sc_ram_areas();
    begin
      setup(1, 32'h0000_0100, 32'h0000_3000, AREA_IRAM, AREA_EXT, 2);
      run(4'h2, 1'b0, 1'b0, 4'h0);
      setup(2, 32'h0000_0041, 32'h0000_0200, AREA_PERIPH, AREA_IRAM, 2);
      run(4'h4, 1'b1, 1'b0, 4'h1);
      $display("Test ram_areas done");
    end
  endtask

  task automatic sc_suspend();
    begin
      setup(3, 32'h0000_4000, 32'h0000_0300, AREA_EXT, AREA_PERIPH, 8);
      run(4'h8, 1'b0, 1'b1, 4'h2);
      $display("Test suspend done");
    end
  endtask

  // Two pins, each its own trigger, fall together
  task automatic sc_priority();
    begin
      setup(1, 32'h0000_5000, 32'h0000_6000, AREA_EXT, AREA_EXT, 3);
      setup(2, 32'h0000_7002, 32'h0000_8000, AREA_EXT, AREA_PERIPH, 2);
      run(4'h6, 1'b1, 1'b0, 4'h1);
      $display("Test priority done");
    end
  endtask

  // Reset in mid-transfer drops the channel; the block then serves a fresh one
  task automatic sc_reset_mid();
    begin
      setup(0, 32'h0000_9000, 32'h0000_A000, AREA_EXT, AREA_EXT, 4);
      active = 4'h1;
      rd_q.delete();
      rd_n[0] = 0;
      wr_n[0] = 0;
      @(posedge clk);
      lat <= 4'h0;
      sw_start <= 4'h1;
      @(posedge clk);
      sw_start <= 4'h0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      `CHECK("pre_busy", 1'b1, dma_busy)
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHECK("rst_busy", 1'b0, dma_busy)
      `CHECK("rst_mem_req", 1'b0, mem_req)
      `CHECK("rst_ack", 4'hF, chan_ack_out_n)
      `CHECK("rst_ram_grant", 1'b0, cpu_ram_grant)
      `CHECK("rst_rom_grant", 1'b0, cpu_rom_grant)
      @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      `CHECK("rel_rom_grant", 1'b1, cpu_rom_grant)
      `CHECK("rel_ram_grant", 1'b1, cpu_ram_grant)
      repeat (8) @(posedge clk);
      @(negedge clk);
      `CHECK("rel_idle", 1'b0, dma_busy)
      setup(0, 32'h0000_9001, 32'h0000_A001, AREA_EXT, AREA_EXT, 2);
      run(4'h1, 1'b0, 1'b0, 4'h0);
      $display("Test reset_mid done");
    end
  endtask

  initial begin
    repeat (10) @(posedge clk);
    `CHECK("reset_ack", 4'hF, chan_ack_out_n)
    `CHECK("reset_req", 1'b0, mem_req)
    rstn <= 1'b1;
    @(posedge clk);
    sc_fifo_ext();
    sc_ram_areas();
    sc_suspend();
    sc_priority();
    sc_reset_mid();
    give_verdict();
  end
endmodule
